//--- hdl/fpc_pkg.sv
// Constants and state encodings for the front panel power control block.
// Assumes a free-running 100 MHz system clock and a power-on reset.
package fpc_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned HOLD_MS       = 50;
    localparam int unsigned LOCKOUT_S     = 2;
    localparam int unsigned BLINK_HALF_MS = 500;
    // Times round down; these divide exactly at 100 MHz
    localparam int unsigned HOLD_CYC      = (CLK_HZ / 1000) * HOLD_MS;
    localparam int unsigned LOCKOUT_CYC   = CLK_HZ * LOCKOUT_S;
    localparam int unsigned BLINK_CYC     = (CLK_HZ / 1000) * BLINK_HALF_MS;
    localparam int unsigned CNT_W         = 28;

    // Power states, one-hot
    typedef enum logic [2:0] {
        FPC_OFF     = 3'b001,
        FPC_STANDBY = 3'b010,
        FPC_ON      = 3'b100
    } fpc_pwr_e;

    // Indicator pattern select values
    localparam logic [1:0] PAT_DEFAULT = 2'h0;
    localparam logic [1:0] PAT_STEADY  = 2'h1; // Steady in standby too
    localparam logic [1:0] PAT_DARK    = 2'h2; // Dark in standby
    localparam logic [1:0] PAT_SWAP    = 2'h3; // Colours swapped
endpackage : fpc_pkg

//--- hdl/fpc_front_panel.sv
// Front panel power switch debounce, reset switch and power/disk LEDs.
// Assumes switch inputs are already synchronous to CLOCK_I.
`timescale 1ns/1ps
module fpc_front_panel
    import fpc_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES    = HOLD_CYC,    // Debounce hold
    parameter int unsigned LOCKOUT_CYCLES = LOCKOUT_CYC, // Lockout
    parameter int unsigned BLINK_CYCLES   = BLINK_CYC    // Blink half
)
(
    input  wire logic       CLOCK_I,         // 100 MHz clock
    input  wire logic       RST_N_I,         // Sync reset, active low
    input  wire logic       CE_I,            // Clock enable
    input  wire logic       POWER_REQUEST_N_I, // Power switch, low closed
    input  wire logic       RESET_SWITCH_N_I,  // Reset switch, low closed
    input  wire logic       SLEEP_REQ_I,     // System asks standby
    input  wire logic       WAKE_REQ_I,      // Wake event from standby
    input  wire logic       DISK_BUSY_I,     // Disk transfer active
    input  wire logic [1:0] PATTERN_SEL_I,   // Indicator pattern
    output logic            POWER_TOGGLE_O,  // Accepted request pulse
    output logic            POWERED_O,       // Board power on level
    output logic            BOARD_RESET_N_O, // Board reset, active low
    output logic            SELF_TEST_O,     // Self test start pulse
    output logic            INDICATOR_PRIMARY_COLOUR_O,   // Main LED
    output logic            INDICATOR_SECONDARY_COLOUR_O, // Alt LED
    output logic            DISK_ACTIVITY_INDICATOR_N_O   // Disk LED
);

    fpc_pwr_e         pwr, next_pwr;
    logic [CNT_W-1:0] hold_cnt, next_hold_cnt;
    logic [CNT_W-1:0] lock_cnt, next_lock_cnt;
    logic [CNT_W-1:0] blink_cnt, next_blink_cnt;
    logic             blink, next_blink;
    logic             armed, next_armed;
    logic             rst_seen, next_rst_seen;
    logic             toggle, next_toggle;
    logic             st_pulse, next_st_pulse;
    logic             led_p, next_led_p;
    logic             led_s, next_led_s;
    logic             disk_n, next_disk_n;
    logic             locked;
    logic             accept;

    assign locked = (lock_cnt != '0);
    // Accept once the low run reaches the hold; armed blocks re-fire
    assign accept = !POWER_REQUEST_N_I && !locked && armed
                    && (hold_cnt == CNT_W'(HOLD_CYCLES - 1));

    // Debounce, lockout and power state
    always_comb
    begin
        next_hold_cnt = hold_cnt;
        next_lock_cnt = lock_cnt;
        next_armed    = armed;
        next_pwr      = pwr;
        next_toggle   = 1'b0;
        if (POWER_REQUEST_N_I || locked)
            next_hold_cnt = '0; // Bounce restarts the count
        else if (armed && !accept)
            next_hold_cnt = hold_cnt + CNT_W'(1);
        if (POWER_REQUEST_N_I)
            next_armed = 1'b1; // Held switch must open again
        if (locked)
            next_lock_cnt = lock_cnt - CNT_W'(1);
        if (accept)
        begin
            next_toggle   = 1'b1;
            next_armed    = 1'b0;
            next_hold_cnt = '0;
            next_lock_cnt = CNT_W'(LOCKOUT_CYCLES);
        end
        case (pwr)
            FPC_OFF:     if (accept) next_pwr = FPC_ON;
            FPC_ON:
                if (accept)           next_pwr = FPC_OFF;
                else if (SLEEP_REQ_I) next_pwr = FPC_STANDBY;
            FPC_STANDBY:
                if (accept || WAKE_REQ_I) next_pwr = FPC_ON;
            default:     next_pwr = FPC_OFF;
        endcase
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            pwr      <= FPC_OFF;
            hold_cnt <= '0;
            lock_cnt <= '0;
            armed    <= 1'b1;
            toggle   <= 1'b0;
        end
        else if (CE_I)
        begin
            pwr      <= next_pwr;
            hold_cnt <= next_hold_cnt;
            lock_cnt <= next_lock_cnt;
            armed    <= next_armed;
            toggle   <= next_toggle;
        end
    end

    // Reset switch: held reset, self test pulse on release
    always_comb
    begin
        next_rst_seen = !RESET_SWITCH_N_I;
        next_st_pulse = rst_seen && RESET_SWITCH_N_I;
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            rst_seen <= 1'b0;
            st_pulse <= 1'b0;
        end
        else if (CE_I)
        begin
            rst_seen <= next_rst_seen;
            st_pulse <= next_st_pulse;
        end
    end

    // Blink timer and indicator drive; free-running keeps halves equal
    always_comb
    begin
        next_blink_cnt = blink_cnt + CNT_W'(1);
        next_blink     = blink;
        if (blink_cnt == CNT_W'(BLINK_CYCLES - 1))
        begin
            next_blink_cnt = '0;
            next_blink     = !blink;
        end
        next_led_p = 1'b0;
        next_led_s = 1'b0;
        case (pwr)
            FPC_ON:
                if (PATTERN_SEL_I == PAT_SWAP)
                    next_led_s = 1'b1;
                else
                    next_led_p = 1'b1;
            FPC_STANDBY:
                case (PATTERN_SEL_I)
                    PAT_STEADY: next_led_s = 1'b1;
                    PAT_DARK:   next_led_s = 1'b0;
                    PAT_SWAP:   next_led_p = blink;
                    default:    next_led_s = blink;
                endcase
            default: ; // Off: both dark
        endcase
        next_disk_n = !DISK_BUSY_I;
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            blink_cnt <= '0;
            blink     <= 1'b0;
            led_p     <= 1'b0;
            led_s     <= 1'b0;
            disk_n    <= 1'b1;
        end
        else if (CE_I)
        begin
            blink_cnt <= next_blink_cnt;
            blink     <= next_blink;
            led_p     <= next_led_p;
            led_s     <= next_led_s;
            disk_n    <= next_disk_n;
        end
    end

    // Output drive, all from flip-flops
    assign POWER_TOGGLE_O               = toggle;
    assign POWERED_O                    = pwr != FPC_OFF;
    assign BOARD_RESET_N_O              = !rst_seen;
    assign SELF_TEST_O                  = st_pulse;
    assign INDICATOR_PRIMARY_COLOUR_O   = led_p;
    assign INDICATOR_SECONDARY_COLOUR_O = led_s;
    assign DISK_ACTIVITY_INDICATOR_N_O  = disk_n;

    // Checks; most look one enabled cycle after their cause, short_press_a and lockout_hold_a look in the same cycle
    short_press_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        $rose(toggle) |-> $past(hold_cnt) == CNT_W'(HOLD_CYCLES - 1))
        else $error("request accepted before hold time");
    lockout_hold_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        toggle |-> lock_cnt == CNT_W'(LOCKOUT_CYCLES))
        else $error("lockout not loaded on accept");
    no_locked_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        (locked && CE_I) |=> !toggle)
        else $error("request accepted during lockout");
    single_toggle_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        (CE_I && toggle) |=> !toggle)
        else $error("accept pulse longer than one cycle");
    reset_drive_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        (CE_I && !RESET_SWITCH_N_I) |=> !BOARD_RESET_N_O)
        else $error("board reset not asserted");
    self_test_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        (CE_I && !BOARD_RESET_N_O && RESET_SWITCH_N_I) |=> SELF_TEST_O)
        else $error("self test not started on release");
    off_dark_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        (CE_I && pwr == FPC_OFF) |=> !led_p && !led_s)
        else $error("indicator lit while off");
    on_blue_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        (CE_I && pwr == FPC_ON && PATTERN_SEL_I == PAT_DEFAULT)
        |=> led_p && !led_s)
        else $error("primary not steady when on");
    amber_blink_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        (CE_I && pwr == FPC_STANDBY && PATTERN_SEL_I == PAT_DEFAULT)
        |=> led_s == $past(blink) && !led_p)
        else $error("standby blink wrong");
    // Blink may flip only at the end of a half, never elsewhere
    blink_half_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        CE_I |=> $changed(blink)
            == ($past(blink_cnt) == CNT_W'(BLINK_CYCLES - 1)))
        else $error("blink half period wrong");
    disk_led_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        (CE_I && DISK_BUSY_I) |=> !disk_n)
        else $error("disk indicator not lit");
    cov_accept_c:    cover property (@(posedge CLOCK_I) toggle);
    cov_standby_c:   cover property (@(posedge CLOCK_I) pwr == FPC_STANDBY);
    cov_self_test_c: cover property (@(posedge CLOCK_I) st_pulse);

endmodule // fpc_front_panel

//--- dv/fpc_panel_model.sv
// Front panel switch model: momentary contacts, open reads high.
// Assumes the bench calls press from its main sequence only.
`timescale 1ns/1ps
module fpc_panel_model
(
    input  wire logic clk_i,   // Bench clock
    output logic      pwr_n_o, // Power switch, low closed
    output logic      rst_n_o  // Reset switch, low closed
);
    // Open contacts sit at the pull-up level
    initial
    begin
        pwr_n_o = 1'b1;
        rst_n_o = 1'b1;
    end
    // Close one contact for n cycles, moving off the sampling edge
    task automatic press(input bit which, input int n);
        @(negedge clk_i);
        if (which)
            rst_n_o = 1'b0;
        else
            pwr_n_o = 1'b0;
        repeat (n) @(negedge clk_i);
        rst_n_o = 1'b1;
        pwr_n_o = 1'b1;
    endtask
endmodule // fpc_panel_model

//--- dv/tb_top.sv
// Bench for the front panel block: switch timing, reset and indicators.
// Assumes shortened counts so the whole run takes a few hundred cycles.
`timescale 1ns/1ps
module tb_top;
    import fpc_pkg::*;
    localparam int H = 5, L = 20, B = 4;
    logic       clk, rst_n, sleep, wake, busy, ce;
    logic       tog, pwd, brst_n, stp, pri, sec, dsk_n;
    logic [1:0] sel;
    wire logic  pw_n, rs_n;
    int         bad_count, n_tests, seed, n_tog, n_rst, n_stp;

    fpc_front_panel #(.HOLD_CYCLES(H), .LOCKOUT_CYCLES(L),
        .BLINK_CYCLES(B)) uut (.CLOCK_I(clk), .RST_N_I(rst_n),
        .CE_I(ce), .POWER_REQUEST_N_I(pw_n), .RESET_SWITCH_N_I(rs_n),
        .SLEEP_REQ_I(sleep), .WAKE_REQ_I(wake), .DISK_BUSY_I(busy),
        .PATTERN_SEL_I(sel), .POWER_TOGGLE_O(tog), .POWERED_O(pwd),
        .BOARD_RESET_N_O(brst_n), .SELF_TEST_O(stp),
        .INDICATOR_PRIMARY_COLOUR_O(pri),
        .INDICATOR_SECONDARY_COLOUR_O(sec),
        .DISK_ACTIVITY_INDICATOR_N_O(dsk_n));
    fpc_panel_model pm (.clk_i(clk), .pwr_n_o(pw_n), .rst_n_o(rs_n));

    always #5 clk = ~clk;
    // Pulse counters, so a one-cycle output is never missed
    always @(posedge clk)
    begin
        n_tog  <= n_tog + (tog === 1'b1);
        n_rst  <= n_rst + (brst_n === 1'b0);
        n_stp  <= n_stp + (stp === 1'b1);
    end

    task automatic chk(input string nm, input logic [4:0] e,
                       input logic [4:0] g);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // Lit samples out of 16 for state 0 off, 1 standby, 2 on
    function automatic logic [4:0] exp_hi(int st, logic [1:0] p, bit s);
        if (st == 2) return (s == (p == PAT_SWAP)) ? 5'h10 : 5'h0;
        if (st == 0 || p == PAT_DARK) return 5'h0;
        if (p == PAT_STEADY) return s ? 5'h10 : 5'h0;
        return (s == (p == PAT_DEFAULT)) ? 5'h08 : 5'h0;
    endfunction
    // Sixteen samples span two full blink periods, so halves must match
    task automatic led(input int st, input logic [1:0] p);
        logic [4:0] hp, hs;
        sel = p;
        hp = 5'h0;
        hs = 5'h0;
        repeat (3) @(negedge clk);
        repeat (16)
        begin
            @(negedge clk);
            hp = hp + pri;
            hs = hs + sec;
        end
        chk("primary", exp_hi(st, p, 0), hp);
        chk("secondary", exp_hi(st, p, 1), hs);
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog, far beyond the expected run length
    initial
    begin
        #100us;
        bad_count++;
        close_out();
    end
    // Main sequence
    initial
    begin
        // Counters are int and start at zero; clock enable starts high
        {clk, rst_n, sleep, wake, busy, ce} = 6'h01;
        {sel, seed} = {PAT_DEFAULT, 32'ha660};
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        led(0, PAT_DEFAULT);
        pm.press(0, H - 1);
        repeat (3) @(negedge clk);
        chk("toggles", 5'h0, n_tog[4:0]);
        pm.press(0, H);
        repeat (3) @(negedge clk);
        chk("toggles", 5'h1, n_tog[4:0]);
        chk("powered", 5'h1, pwd);
        pm.press(0, H + 3);
        repeat (L) @(negedge clk);
        chk("locked toggles", 5'h1, n_tog[4:0]);
        led(2, PAT_DEFAULT);
        led(2, PAT_SWAP);
        sleep = 1'b1;
        repeat (2) @(negedge clk);
        sleep = 1'b0;
        for (int p = 0; p < 4; p++) led(1, p[1:0]);
        wake = 1'b1;
        repeat (2) @(negedge clk);
        wake = 1'b0;
        led(2, PAT_DEFAULT);
        // Random disk traffic, seen one cycle later; one bit, zero-filled
        repeat (24)
        begin
            @(negedge clk);
            chk("disk", {4'h0, !busy}, {4'h0, dsk_n});
            busy = 1'($random(seed));
        end
        // Enable low freezes the debounce, so even a long press is lost
        ce = 1'b0;
        pm.press(0, H + 2);
        repeat (3) @(negedge clk);
        ce = 1'b1;
        chk("frozen toggles", 5'h1, n_tog[4:0]);
        chk("frozen powered", 5'h1, pwd);
        pm.press(0, H);
        repeat (3) @(negedge clk);
        chk("powered", 5'h0, pwd);
        led(0, PAT_SWAP);
        pm.press(1, 3);
        repeat (3) @(negedge clk);
        chk("reset cycles", 5'h3, n_rst[4:0]);
        chk("self tests", 5'h1, n_stp[4:0]);
        close_out();
    end
endmodule // tb_top
